//--- bench/stc_timer_tb.sv
// Self-checking testbench of the standard timer compare block
`timescale 1ns/10ps

module stc_timer_tb;
  import stc_pkg::*;

  // ==========================================================
  // Stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        cap_in = 1'b0;
  wire         awready, wready, bvalid, arready, rvalid, tout, toe;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          num_errors = 0;
  int          samples_checked = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  // One timer clock per system clock keeps the periods short
  stc_timer #(.TIMER_DIV(1)) dut_u (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_pin_in(cap_in), .timer_output_pin(tout),
    .timer_output_oe(toe)
  );

  // ==========================================================
  // Compare, bus and measuring tasks
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready === 1'b1)
      begin
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
      end
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_val({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk_val(d, {24'h0, e});
    chk_val({30'h0, r}, {30'h0, STC_RESP_OKAY});
  endtask

  function automatic logic [7:0] c1(logic [1:0] m, logic [1:0] a,
                                    logic i, logic v, logic s, logic c);
    stc_ctl1_type t;
    t = '{m, a, i, v, s, c};
    return t;
  endfunction

  // Control one is only changed while the timer is off
  task automatic start(input logic [7:0] cv);
    wr(STC_OFF_CTL0, 8'h00, STC_RESP_OKAY);
    wr(STC_OFF_CTL1, cv, STC_RESP_OKAY);
    wr(STC_OFF_CTL0, 8'h08, STC_RESP_OKAY);
  endtask

  // Cycles spent at lvl, then at the other level
  task automatic measure(input logic lvl, output int n_on,
                         output int n_off);
    n_on = 0;
    n_off = 0;
    do @(posedge clk); while (tout !== ~lvl);
    do @(posedge clk); while (tout !== lvl);
    do begin @(posedge clk); n_on++; end while (tout === lvl);
    do begin @(posedge clk); n_off++; end while (tout === ~lvl);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [7:0]  offs[6];
    logic [31:0] d;
    logic [1:0]  r;
    offs = '{STC_OFF_CTL1, STC_OFF_CNTL, STC_OFF_CNTH,
             STC_OFF_CAL, STC_OFF_CAH, STC_OFF_CP};
    foreach (offs[k])
      rd_chk(offs[k], STC_BYTE_RST);
    rd(8'h1C, d, r);
    chk_val({30'h0, r}, {30'h0, STC_RESP_SLVERR});
    chk_val(d, 32'h0);
    wr(8'h1C, 8'h5A, STC_RESP_SLVERR);
    wr(STC_OFF_CAL, 8'h34, STC_RESP_OKAY);
    wr(STC_OFF_CAH, 8'h12, STC_RESP_OKAY);
    wr(STC_OFF_CTL1, 8'hC5, STC_RESP_OKAY);
    rd_chk(STC_OFF_CAL, 8'h34);
    rd_chk(STC_OFF_CAH, 8'h12);
    rd_chk(STC_OFF_CTL1, 8'hC5);
  endtask

  // Every action code, initial level and polarity in compare mode
  task automatic t_cmp;
    logic e;
    wr(STC_OFF_CAL, 8'h10, STC_RESP_OKAY);
    wr(STC_OFF_CAH, 8'h00, STC_RESP_OKAY);
    for (int a = 0; a < 4; a++)
      for (int k = 0; k < 4; k++)
      begin
        start(c1(STC_MODE_CMP, 2'(a), k[1], k[0], 1'b0, 1'b0));
        repeat (4) @(posedge clk);
        chk_pin(tout, k[1] ^ k[0]);
        chk_pin(toe, 1'b1);
        repeat (40) @(posedge clk);
        e = (a == 0) ? k[1] : (a == 1) ? 1'b0 : (a == 2) ? 1'b1 : ~k[1];
        chk_pin(tout, e ^ k[0]);
      end
  endtask

  // Stopped counter holds, ignores writes, restarts from zero
  task automatic t_stop;
    logic [31:0] d;
    logic [1:0]  r;
    wr(STC_OFF_CTL0, 8'h00, STC_RESP_OKAY);
    rd(STC_OFF_CNTL, d, r);
    repeat (10) @(posedge clk);
    wr(STC_OFF_CNTL, 8'hAA, STC_RESP_OKAY);
    rd_chk(STC_OFF_CNTL, d[7:0]);
    wr(STC_OFF_CTL0, 8'h08, STC_RESP_OKAY);
    rd_chk(STC_OFF_CNTH, 8'h00);
  endtask

  // Toggle on A with P clearing: half period is 256 times P
  task automatic t_period;
    int h;
    int l;
    wr(STC_OFF_CAL, 8'h80, STC_RESP_OKAY);
    for (int p = 1; p < 3; p++)
    begin
      wr(STC_OFF_CP, 8'(p), STC_RESP_OKAY);
      start(c1(STC_MODE_CMP, STC_ACT_TOG, 1'b0, 1'b0, 1'b0, 1'b0));
      measure(1'b1, h, l);
      chk_val(h, 256 * p);
      chk_val(l, 256 * p);
    end
  endtask

  // PWM duty and period, polarity and swap; clear source set
  task automatic t_pwm;
    int h;
    int l;
    wr(STC_OFF_CP, 8'h01, STC_RESP_OKAY);
    wr(STC_OFF_CAL, 8'h40, STC_RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      start(c1(STC_MODE_PWM, STC_ACT_PWM, k[1], k[0], 1'b0, 1'b1));
      measure(k[1] ^ k[0], h, l);
      chk_val(h, 64);
      chk_val(l, 192);
    end
    for (int a = 0; a < 2; a++)
    begin
      start(c1(STC_MODE_PWM, 2'(a), 1'b1, 1'b0, 1'b0, 1'b0));
      repeat (300) @(posedge clk);
      chk_pin(tout, a[0]);
    end
    wr(STC_OFF_CAL, 8'h00, STC_RESP_OKAY);
    wr(STC_OFF_CAH, 8'h02, STC_RESP_OKAY);
    start(c1(STC_MODE_PWM, STC_ACT_PWM, 1'b1, 1'b0, 1'b1, 1'b0));
    measure(1'b1, h, l);
    chk_val(h, 256);
    chk_val(l, 256);
  endtask

  // Single pulse: active from the run edge until the A match
  task automatic t_pulse;
    int n;
    n = 0;
    start(c1(STC_MODE_PWM, STC_ACT_PULSE, 1'b1, 1'b0, 1'b0, 1'b0));
    do @(posedge clk); while (tout !== 1'b1);
    do begin @(posedge clk); n++; end while (tout === 1'b1);
    chk_val(n, 512);
    rd_chk(STC_OFF_CTL0, 8'h00);
  endtask

  // Capture copies the stopped counter into compare A
  task automatic t_cap;
    logic [31:0] d;
    logic [1:0]  r;
    start(c1(STC_MODE_CAP, STC_CAP_RISE, 1'b0, 1'b0, 1'b0, 1'b0));
    repeat (20) @(posedge clk);
    wr(STC_OFF_CTL0, 8'h00, STC_RESP_OKAY);
    rd(STC_OFF_CNTL, d, r);
    cap_in <= 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(STC_OFF_CAL, d[7:0]);
    rd_chk(STC_OFF_CAH, 8'h00);
  endtask

  // Pin driven only in compare and PWM modes
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      start(c1(2'(m), 2'h0, 1'b1, 1'b1, 1'b0, 1'b0));
      repeat (4) @(posedge clk);
      chk_pin(toe, m == 0 || m == 2);
      if (m == 3)
        chk_pin(tout, 1'b0);
    end
  endtask

  // ==========================================================
  // Verdict, watchdog and main sequence
  task automatic give_verdict;
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    give_verdict;
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_cmp;
    t_stop;
    t_period;
    t_pwm;
    t_pulse;
    t_cap;
    t_modes;
    give_verdict;
  end

endmodule

//--- core/stc_pkg.sv
// Shared constants, encodings and types of the standard timer compare block
package stc_pkg;

  // ==========================================================
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] STC_OFF_CTL0 = 8'h00;   // Run and pause control
  localparam logic [7:0] STC_OFF_CTL1 = 8'h04;   // timer_control_one
  localparam logic [7:0] STC_OFF_CNTL = 8'h08;   // counter_low_byte
  localparam logic [7:0] STC_OFF_CNTH = 8'h0C;   // counter_high_byte
  localparam logic [7:0] STC_OFF_CAL  = 8'h10;   // compare_a_low_byte
  localparam logic [7:0] STC_OFF_CAH  = 8'h14;   // compare_a_high_byte
  localparam logic [7:0] STC_OFF_CP   = 8'h18;   // compare_p_value

  // ==========================================================
  // Field positions and reset values
  localparam int          STC_RUN_BIT   = 3;      // counter_run in control 0
  localparam int          STC_PAUSE_BIT = 7;      // Pause in control 0
  localparam logic [7:0]  STC_CTL0_MASK = 8'h88;  // Implemented control 0 bits
  localparam logic [7:0]  STC_BYTE_RST  = 8'h00;  // Reset of every byte register
  localparam logic [15:0] STC_CNT_RST   = 16'h0000;
  localparam logic [15:0] STC_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] STC_CNT_ONE   = 16'h0001;
  localparam logic [7:0]  STC_CP_ZERO   = 8'h00;
  localparam logic [16:0] STC_FULL_SPAN = 17'h10000; // 65536 timer clocks

  // ==========================================================
  // Mode field encodings
  localparam logic [1:0] STC_MODE_CMP = 2'h0;    // Compare-match output
  localparam logic [1:0] STC_MODE_CAP = 2'h1;    // Capture input
  localparam logic [1:0] STC_MODE_PWM = 2'h2;    // PWM or single pulse
  localparam logic [1:0] STC_MODE_TC  = 2'h3;    // Timer/counter

  // Output action field, compare-match mode
  localparam logic [1:0] STC_ACT_NONE = 2'h0;
  localparam logic [1:0] STC_ACT_LOW  = 2'h1;
  localparam logic [1:0] STC_ACT_HIGH = 2'h2;
  localparam logic [1:0] STC_ACT_TOG  = 2'h3;
  // Output action field, PWM and single-pulse mode
  localparam logic [1:0] STC_ACT_INACT = 2'h0;
  localparam logic [1:0] STC_ACT_ACT   = 2'h1;
  localparam logic [1:0] STC_ACT_PWM   = 2'h2;
  localparam logic [1:0] STC_ACT_PULSE = 2'h3;
  // Output action field, capture mode
  localparam logic [1:0] STC_CAP_RISE = 2'h0;
  localparam logic [1:0] STC_CAP_FALL = 2'h1;
  localparam logic [1:0] STC_CAP_BOTH = 2'h2;

  // AXI responses
  localparam logic [1:0] STC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] STC_RESP_SLVERR = 2'h2;

  // Layout of timer_control_one, bit 7 first
  typedef struct packed {
    logic [1:0] mode_sel;              // mode_sel_hi, mode_sel_lo
    logic [1:0] output_action;         // output_action_hi, output_action_lo
    logic       output_initial_level;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_sel;
  } stc_ctl1_type;

endpackage

//--- core/stc_timer.sv
// Standard timer with compare output, PWM, single pulse and capture
// ============================================================
// What this block does
// RULE_01: Compare-match mode: A match drives pin low, high, toggles, or nothing.
// RULE_02: Action codes: 00 none,01 low,10 high,11 toggle; PWM: inactive,active,PWM,pulse.
// RULE_03: Requested level equal to initial level shows no pin change.
// RULE_04: Run bit rising edge returns the pin to its initial level.
// RULE_05: Software changes PWM action only while the timer is off.
// RULE_06: Compare-match mode: initial-level bit sets pin level before any match.
// RULE_07: PWM and single pulse: initial-level bit selects the active level.
// RULE_08: Invert bit set inverts the pin against the internal signal.
// RULE_09: Initial-level and invert bits do nothing in timer/counter mode.
// RULE_10: Swap 0: P sets period, A duty; swap 1: A period, P duty.
// RULE_11: Clear source 1 clears on A match; 0 on P match or overflow.
// RULE_12: Overflow clearing only when compare-P is zero; counter wraps at maximum.
// RULE_13: Clear source ignored in PWM, single-pulse and capture modes.
// RULE_14: Counter readable, not writable, as low and high bytes, reset zero.
// RULE_15: Compare-A held in two read/write bytes, both reset to zero.
// RULE_16: Compare-P compared against counter upper byte only, multiples of 256.
// RULE_17: P match period 65536 clocks for zero, else 256 times value.
// RULE_18: Five modes: compare, PWM, single pulse, capture, timer/counter.
// RULE_19: Mode codes: 00 compare, 01 capture, 10 PWM/pulse, 11 timer.
// RULE_20: Run rising clears counter; run falling stops it holding its value.
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps

module stc_timer
  import stc_pkg::*;
#(
  parameter int TIMER_DIV = 4                 // System clocks per timer clock
)
(
  input  wire logic        clk,              // System clock, 10 MHz
  input  wire logic        rst_n,            // Asynchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Write byte strobes
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [7:0]  s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  input  wire logic        capture_pin_in,   // Capture input pin level
  output logic             timer_output_pin, // Timer output pin level
  output logic             timer_output_oe   // High while pin is driven
);

  // Divider must give at least one system clock per timer clock
  if (TIMER_DIV < 1) begin : g_bad_div
    $error("TIMER_DIV must be at least 1");
  end

  // ==========================================================
  // Registers
  logic [7:0]   ctl0_r;
  stc_ctl1_type ctl1_r;
  logic [15:0]  cnt_r;
  logic [15:0]  ca_r;
  logic [7:0]   cp_r;
  logic         run_d_r;
  logic         out_int_r;
  logic         pin_r;
  logic         oe_r;
  logic [15:0]  div_r;
  logic         tick_r;
  logic         cap_s1_r;
  logic         cap_s2_r;
  logic         cap_s3_r;

  // ==========================================================
  // AXI4-Lite slave: both write channels taken together
  logic         awready_r;
  logic         wready_r;
  logic         bvalid_r;
  logic [1:0]   bresp_r;
  logic         arready_r;
  logic         rvalid_r;
  logic [1:0]   rresp_r;
  logic [31:0]  rdata_r;
  logic [7:0]   rd_byte;
  logic         rd_hit;

  wire wr_go   = s_axi_awvalid && s_axi_wvalid && !awready_r && !bvalid_r;
  wire rd_go   = s_axi_arvalid && !arready_r && !rvalid_r;
  wire wr_lane = s_axi_wstrb[0];
  wire [7:0] wbyte = s_axi_wdata[7:0];
  wire wr_ctl0 = wr_go && wr_lane && s_axi_awaddr == STC_OFF_CTL0;
  wire wr_ctl1 = wr_go && wr_lane && s_axi_awaddr == STC_OFF_CTL1;
  wire wr_cal  = wr_go && wr_lane && s_axi_awaddr == STC_OFF_CAL;
  wire wr_cah  = wr_go && wr_lane && s_axi_awaddr == STC_OFF_CAH;
  wire wr_cp   = wr_go && wr_lane && s_axi_awaddr == STC_OFF_CP;
  // Counter bytes decode but take no write
  wire wr_hit  = s_axi_awaddr == STC_OFF_CTL0 || s_axi_awaddr == STC_OFF_CTL1
              || s_axi_awaddr == STC_OFF_CNTL || s_axi_awaddr == STC_OFF_CNTH
              || s_axi_awaddr == STC_OFF_CAL  || s_axi_awaddr == STC_OFF_CAH
              || s_axi_awaddr == STC_OFF_CP;

  // Read data selection
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_byte = STC_BYTE_RST;
    if (s_axi_araddr == STC_OFF_CTL0)
      rd_byte = ctl0_r;
    else if (s_axi_araddr == STC_OFF_CTL1)
      rd_byte = ctl1_r;
    else if (s_axi_araddr == STC_OFF_CNTL)
      rd_byte = cnt_r[7:0];                  // RULE_14
    else if (s_axi_araddr == STC_OFF_CNTH)
      rd_byte = cnt_r[15:8];                 // RULE_14
    else if (s_axi_araddr == STC_OFF_CAL)
      rd_byte = ca_r[7:0];                   // RULE_15
    else if (s_axi_araddr == STC_OFF_CAH)
      rd_byte = ca_r[15:8];                  // RULE_15
    else if (s_axi_araddr == STC_OFF_CP)
      rd_byte = cp_r;
    else
      rd_hit = 1'b0;
  end

  // Write channel handshake and response
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= STC_RESP_OKAY;
    end
    else
    begin
      awready_r <= wr_go;
      wready_r  <= wr_go;
      // Response only once both channels have been handed over
      if (awready_r)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? STC_RESP_OKAY : STC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read channel handshake and data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= STC_RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end
    else
    begin
      arready_r <= rd_go;
      // Data only once the address has been handed over
      if (arready_r)
      begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_hit ? STC_RESP_OKAY : STC_RESP_SLVERR;
        rdata_r  <= {24'h000000, rd_byte};
      end
      else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Timer clock enable and capture pin synchroniser
  wire [15:0] div_last = 16'(TIMER_DIV - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_r    <= STC_CNT_RST;
      tick_r   <= 1'b0;
      cap_s1_r <= 1'b0;
      cap_s2_r <= 1'b0;
      cap_s3_r <= 1'b0;
    end
    else
    begin
      div_r    <= (div_r >= div_last) ? STC_CNT_RST : div_r + STC_CNT_ONE;
      tick_r   <= div_r >= div_last;
      cap_s1_r <= capture_pin_in;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
    end
  end

  // ==========================================================
  // Counter, comparators and clear selection
  wire [1:0] mode     = ctl1_r.mode_sel;       // RULE_18 RULE_19
  wire [1:0] act      = ctl1_r.output_action;
  wire       ilvl     = ctl1_r.output_initial_level;
  wire       run      = ctl0_r[STC_RUN_BIT];
  wire       run_rise = run && !run_d_r;
  wire       counting = tick_r && run && !ctl0_r[STC_PAUSE_BIT]; // RULE_20
  wire [15:0] cnt_inc = cnt_r + STC_CNT_ONE;
  wire is_pulse = mode == STC_MODE_PWM && act == STC_ACT_PULSE;
  wire is_pwm   = mode == STC_MODE_PWM && act != STC_ACT_PULSE;
  wire is_cmp   = mode == STC_MODE_CMP || mode == STC_MODE_TC;
  wire a_hit    = counting && cnt_inc == ca_r;
  // Upper byte only, zero means the counter runs the full span
  wire p_hit    = counting && cp_r != STC_CP_ZERO
               && cnt_inc == {cp_r, STC_BYTE_RST};             // RULE_16 RULE_17
  // Period source: swap picks A, otherwise P with wrap at zero
  wire pwm_clr  = ctl1_r.period_duty_swap ? a_hit : p_hit;     // RULE_10
  wire cmp_clr  = ctl1_r.clear_source_sel ? a_hit : p_hit;     // RULE_11 RULE_12
  // Clear source only steers compare and timer modes
  wire clr_now  = is_cmp ? cmp_clr : (is_pwm ? pwm_clr : 1'b0); // RULE_13
  wire [16:0] duty = ctl1_r.period_duty_swap
                   ? (cp_r == STC_CP_ZERO ? STC_FULL_SPAN
                                          : {1'b0, cp_r, STC_BYTE_RST})
                   : {1'b0, ca_r};                             // RULE_10
  wire pwm_act  = {1'b0, cnt_r} < duty;
  wire sp_stop  = is_pulse && a_hit;
  wire cap_edge = mode == STC_MODE_CAP && (
                  (act == STC_CAP_RISE && cap_s2_r && !cap_s3_r) ||
                  (act == STC_CAP_FALL && !cap_s2_r && cap_s3_r) ||
                  (act == STC_CAP_BOTH && cap_s2_r != cap_s3_r));

  // Counter update: run rising clears it, otherwise counts or clears
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= STC_CNT_RST;
    else if (run_rise)
      cnt_r <= STC_CNT_RST;                  // RULE_20
    else if (counting)
      cnt_r <= clr_now ? STC_CNT_RST : cnt_inc; // RULE_11 RULE_12
  end

  // Control and compare registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl0_r  <= STC_BYTE_RST;
      ctl1_r  <= STC_BYTE_RST;
      ca_r    <= STC_CNT_RST;                // RULE_15
      cp_r    <= STC_BYTE_RST;
      run_d_r <= 1'b0;
    end
    else
    begin
      run_d_r <= run;
      if (wr_ctl0)
        ctl0_r <= wbyte & STC_CTL0_MASK;
      else if (sp_stop)
        ctl0_r[STC_RUN_BIT] <= 1'b0;         // Pulse ends on A match
      if (wr_ctl1)
        ctl1_r <= wbyte;
      if (cap_edge)
        ca_r <= cnt_r;                       // Capture wins over a write
      else
      begin
        if (wr_cal)
          ca_r[7:0] <= wbyte;                // RULE_15
        if (wr_cah)
          ca_r[15:8] <= wbyte;               // RULE_15
      end
      if (wr_cp)
        cp_r <= wbyte;
    end
  end

  // ==========================================================
  // Output generation
  logic out_nxt;

  always_comb
  begin
    out_nxt = out_int_r;
    case (mode)
      STC_MODE_CMP:
        if (run_rise)
          out_nxt = ilvl;                    // RULE_04 RULE_06
        else if (a_hit)
          case (act)                         // RULE_01 RULE_02 RULE_03
            STC_ACT_LOW:  out_nxt = 1'b0;
            STC_ACT_HIGH: out_nxt = 1'b1;
            STC_ACT_TOG:  out_nxt = !out_int_r;
            default:      out_nxt = out_int_r;
          endcase
      STC_MODE_PWM:
        case (act)                           // RULE_02 RULE_07
          STC_ACT_INACT: out_nxt = !ilvl;
          STC_ACT_ACT:   out_nxt = ilvl;
          STC_ACT_PWM:   out_nxt = pwm_act ? ilvl : !ilvl;
          default:       out_nxt = (run && !sp_stop) ? ilvl : !ilvl;
        endcase
      default:
        out_nxt = out_int_r;                 // RULE_09
    endcase
  end

  // Pin stage with inversion, pin forced low in timer mode, enable off in timer and capture modes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_int_r <= 1'b0;
      pin_r     <= 1'b0;
      oe_r      <= 1'b0;
    end
    else
    begin
      out_int_r <= out_nxt;
      pin_r     <= (mode == STC_MODE_TC) ? 1'b0
                 : out_int_r ^ ctl1_r.output_invert; // RULE_08 RULE_09
      oe_r      <= mode == STC_MODE_CMP || mode == STC_MODE_PWM;
    end
  end

  assign s_axi_awready    = awready_r;
  assign s_axi_wready     = wready_r;
  assign s_axi_bvalid     = bvalid_r;
  assign s_axi_bresp      = bresp_r;
  assign s_axi_arready    = arready_r;
  assign s_axi_rvalid     = rvalid_r;
  assign s_axi_rresp      = rresp_r;
  assign s_axi_rdata      = rdata_r;
  assign timer_output_pin = pin_r;
  assign timer_output_oe  = oe_r;

  // ==========================================================
  // Assertions
  sequence s_run_edge;
    run_rise && mode == STC_MODE_CMP;
  endsequence

  sequence s_pin_initial;
    out_int_r == $past(ilvl)
    ##1 pin_r == ($past(out_int_r) ^ $past(ctl1_r.output_invert));
  endsequence

  run_restart_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    s_run_edge |=> s_pin_initial)
    else $error("pin not back at initial level after run edge");

  cnt_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
    run_rise |=> cnt_r == STC_CNT_RST)
    else $error("counter not cleared on run edge");

  cnt_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_20
    !run && !run_rise |=> $stable(cnt_r))
    else $error("counter moved while stopped");

  act_high_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    mode == STC_MODE_CMP && !run_rise && a_hit && act == STC_ACT_HIGH
    |=> out_int_r)
    else $error("compare match did not drive high");

  act_toggle_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    mode == STC_MODE_CMP && !run_rise && a_hit && act == STC_ACT_TOG
    |=> out_int_r != $past(out_int_r))
    else $error("compare match did not toggle");

  act_none_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
    mode == STC_MODE_CMP && !run_rise && act == STC_ACT_NONE
    |=> $stable(out_int_r))
    else $error("pin changed with no action selected");

  pin_invert_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    mode != STC_MODE_TC && $stable(mode)
    |=> pin_r == ($past(out_int_r) ^ $past(ctl1_r.output_invert)))
    else $error("pin polarity wrong");

  clr_sel_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
    is_cmp && ctl1_r.clear_source_sel && a_hit && !run_rise
    |=> cnt_r == STC_CNT_RST)
    else $error("A match did not clear counter");

  p_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_16
    is_cmp && !ctl1_r.clear_source_sel && p_hit && !run_rise
    |=> cnt_r == STC_CNT_RST)
    else $error("P match did not clear counter");

  wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
    counting && !run_rise && cnt_r == STC_CNT_MAX |=> cnt_r == STC_CNT_RST)
    else $error("counter did not wrap at maximum");

  pwm_level_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    is_pwm && act == STC_ACT_ACT |=> out_int_r == $past(ilvl))
    else $error("active level not taken from initial-level bit");

endmodule
